/* verilog/sapc_top.sv */
// Serial converter framing and power-mode control
// Summary of operation
// - Code 00: low power after each conversion, full power by the third system clock after the next start bit.
// - Code 11 keeps full power; codes 01 and 10 are reserved for host.
// - Overlapped command bytes allow a conversion every 15 serial clocks.
// - 8-bit conversions finish four serial clocks sooner than 12-bit ones.
// - Shutdown pin low forces power-down by the third system clock, any power code.
// - Result is unsigned straight binary, zero input gives lowest code.
// - Command byte MSB first: start, channel, resolution, input mode, power.
// - Input ignored until high start bit; commands every 15th or 11th clock.
// - Resolution pin low forces 12 bits; high lets command bit choose.
// - Twelve conversion clocks (eight in 8-bit mode), one result bit on each, then output low.
`timescale 1ns/1ns
`default_nettype none
module sapc_top
  import sapc_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic serial_clock_pin,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic res_pin_i,
  input wire logic shutdown_n_pin,
  input wire logic [11:0] adc_code_i,
  output logic dout_o,
  output logic dout_oe_o,
  output sapc_mux_t mux_o,
  output logic sample_hold_o,
  output logic analog_power_on_o,
  output sapc_pwr_state_t power_state_o,
  output logic reserved_code_o
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************

  // Conversion length from pin and command bit
  function automatic logic [3:0] conv_len(input logic pin, input logic bit8);
    begin
      conv_len = (pin && bit8) ? SAPC_CONV_CLKS_8 : SAPC_CONV_CLKS_12;
    end
  endfunction : conv_len

  // Reserved power-select codes
  function automatic logic is_reserved(input logic [1:0] code);
    begin
      is_reserved = (code == SAPC_PD_RSV_A) || (code == SAPC_PD_RSV_B);
    end
  endfunction : is_reserved

  // ****************************************************************
  // Link domain, clocked by the serial clock
  // ****************************************************************
  sapc_link_st_t link_reg;
  sapc_link_st_t link_next;
  logic link_rst;
  logic res_pin_s;
  logic [11:0] code_s;
  logic [7:0] cmd_word;
  logic [3:0] len;

  // Reset and slow pins into the link domain
  sapc_sync2 #(.WIDTH(1)) u_link_rst (
    .clk_i(serial_clock_pin),
    .d_i(srst_i),
    .q_o(link_rst)
  );
  sapc_sync2 #(.WIDTH(1)) u_res_pin (
    .clk_i(serial_clock_pin),
    .d_i(res_pin_i),
    .q_o(res_pin_s)
  );
  sapc_sync2 #(.WIDTH(SAPC_CODE_W)) u_code (
    .clk_i(serial_clock_pin),
    .d_i(adc_code_i),
    .q_o(code_s)
  );

  // Command receiver and result shifter
  always_comb
  begin
    link_next = link_reg;
    cmd_word = {link_reg.rx_sr[6:0], din_i};
    len = conv_len(res_pin_s, cmd_word[SAPC_CMD_RES_POS]);
    if (cs_n_i)
    begin
      // Deselected: abandon frame, keep mux setting
      link_next.rx_state = SAPC_RX_IDLE;
      link_next.rx_cnt = SAPC_CNT_ZERO;
      link_next.conv_cnt = SAPC_CNT_ZERO;
      link_next.dout = 1'b0;
      link_next.hold = 1'b0;
    end
    else
    begin
      // Receiver runs beside the shifter so commands may overlap
      unique case (link_reg.rx_state)
        SAPC_RX_IDLE:
        begin
          if (din_i)
          begin
            link_next.rx_state = SAPC_RX_CMD;
            link_next.rx_sr = {7'h00, din_i};
            link_next.rx_cnt = SAPC_CNT_ONE;
          end
        end
        SAPC_RX_CMD:
        begin
          link_next.rx_sr = cmd_word;
          link_next.rx_cnt = link_reg.rx_cnt + SAPC_CNT_ONE;
          if (link_reg.rx_cnt == SAPC_CMD_LAST_CNT)
          begin
            link_next.rx_state = SAPC_RX_IDLE;
          end
        end
      endcase
      // Result shifter
      if (link_reg.rx_state == SAPC_RX_CMD && link_reg.rx_cnt == SAPC_CMD_LAST_CNT)
      begin
        // Byte complete: hold sample, start conversion
        link_next.mux.channel_select_bits = cmd_word[SAPC_CMD_CHAN_HI:SAPC_CMD_CHAN_LO];
        link_next.mux.single_vs_differential_bit = cmd_word[SAPC_CMD_SGL_POS];
        link_next.pd = cmd_word[SAPC_CMD_PD_HI:SAPC_CMD_PD_LO];
        link_next.out_sr = code_s;
        link_next.conv_cnt = len;
        link_next.dout = 1'b0;
        link_next.hold = 1'b1;
      end
      else if (link_reg.conv_cnt != SAPC_CNT_ZERO)
      begin
        // One result bit per clock, MSB first
        link_next.dout = link_reg.out_sr[SAPC_CODE_W-1];
        link_next.out_sr = {link_reg.out_sr[SAPC_CODE_W-2:0], 1'b0};
        link_next.conv_cnt = link_reg.conv_cnt - SAPC_CNT_ONE;
        if (link_reg.conv_cnt == SAPC_CNT_ONE)
        begin
          link_next.done_tgl = ~link_reg.done_tgl;
          link_next.hold = 1'b0;
        end
      end
      else
      begin
        link_next.dout = SAPC_LOW_PAD[0];
      end
    end
    link_next.active = (link_next.rx_state == SAPC_RX_CMD) ||
                       (link_next.conv_cnt != SAPC_CNT_ZERO);
  end

  // Link state register
  always_ff @(posedge serial_clock_pin)
  begin
    if (link_rst)
    begin
      link_reg <= '{rx_state: SAPC_RX_IDLE, mux: '0, pd: SAPC_PD_AUTO, default: '0};
    end
    else
    begin
      link_reg <= link_next;
    end
  end

  // ****************************************************************
  // System domain: power-mode control
  // ****************************************************************
  sapc_sys_st_t sys_reg;
  sapc_sys_st_t sys_next;
  logic active_s;
  logic done_s;
  logic shutdown_n_pin_n_s;
  logic cs_n_s;
  logic [1:0] pd_s;

  // Link events and pins into the system domain
  sapc_sync2 #(.WIDTH(4)) u_sys_sync (
    .clk_i(clk_i),
    .d_i({link_reg.active, link_reg.done_tgl, shutdown_n_pin, cs_n_i}),
    .q_o({active_s, done_s, shutdown_n_pin_n_s, cs_n_s})
  );
  sapc_sync2 #(.WIDTH(2)) u_pd_sync (
    .clk_i(clk_i),
    .d_i(link_reg.pd),
    .q_o(pd_s)
  );

  // Power state selection
  always_comb
  begin
    sys_next = sys_reg;
    sys_next.done_seen = done_s;
    if (done_s != sys_reg.done_seen)
    begin
      sys_next.applied_pd = pd_s;
    end
    if (!shutdown_n_pin_n_s)
    begin
      sys_next.pwr = SAPC_PWR_SHUTDOWN;
    end
    else if (active_s || sys_next.applied_pd == SAPC_PD_ALWAYS_ON)
    begin
      sys_next.pwr = SAPC_PWR_FULL;
    end
    else
    begin
      sys_next.pwr = SAPC_PWR_AUTO_DOWN;
    end
    sys_next.power_on = (sys_next.pwr == SAPC_PWR_FULL);
    sys_next.reserved_code = is_reserved(sys_next.applied_pd);
    sys_next.dout_oe = ~cs_n_s;
  end

  // System state register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sys_reg <= '{pwr: SAPC_PWR_AUTO_DOWN, applied_pd: SAPC_PD_AUTO, default: '0};
    end
    else
    begin
      sys_reg <= sys_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign dout_o = link_reg.dout;
  assign mux_o = link_reg.mux;
  assign sample_hold_o = link_reg.hold;
  assign dout_oe_o = sys_reg.dout_oe;
  assign analog_power_on_o = sys_reg.power_on;
  assign power_state_o = sys_reg.pwr;
  assign reserved_code_o = sys_reg.reserved_code;

endmodule : sapc_top
`default_nettype wire

/* verilog/sapc_pkg.sv */
// Shared constants and types for the serial converter control block
package sapc_pkg;

  // ****************************************************************
  // Command byte layout
  // ****************************************************************
  localparam int unsigned SAPC_CMD_BITS = 8;
  localparam int unsigned SAPC_CMD_START_POS = 7;
  localparam int unsigned SAPC_CMD_CHAN_HI = 6;
  localparam int unsigned SAPC_CMD_CHAN_LO = 4;
  localparam int unsigned SAPC_CMD_RES_POS = 3;
  localparam int unsigned SAPC_CMD_SGL_POS = 2;
  localparam int unsigned SAPC_CMD_PD_HI = 1;
  localparam int unsigned SAPC_CMD_PD_LO = 0;

  // ****************************************************************
  // Counts and widths
  // ****************************************************************
  localparam int unsigned SAPC_CODE_W = 12;
  localparam int unsigned SAPC_CNT_W = 4;
  localparam logic [3:0] SAPC_CMD_LAST_CNT = 4'h7;
  localparam logic [3:0] SAPC_CONV_CLKS_12 = 4'hc;
  localparam logic [3:0] SAPC_CONV_CLKS_8 = 4'h8;
  localparam logic [3:0] SAPC_CNT_ONE = 4'h1;
  localparam logic [3:0] SAPC_CNT_ZERO = 4'h0;
  localparam logic [3:0] SAPC_LOW_PAD = 4'h0;

  // ****************************************************************
  // Power-select codes
  // ****************************************************************
  localparam logic [1:0] SAPC_PD_AUTO = 2'h0;
  localparam logic [1:0] SAPC_PD_RSV_A = 2'h1;
  localparam logic [1:0] SAPC_PD_RSV_B = 2'h2;
  localparam logic [1:0] SAPC_PD_ALWAYS_ON = 2'h3;

  // ****************************************************************
  // State enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    SAPC_RX_IDLE = 2'b01,
    SAPC_RX_CMD = 2'b10
  } sapc_rx_state_t;

  typedef enum logic [2:0] {
    SAPC_PWR_FULL = 3'b001,
    SAPC_PWR_AUTO_DOWN = 3'b010,
    SAPC_PWR_SHUTDOWN = 3'b100
  } sapc_pwr_state_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [2:0] channel_select_bits;
    logic single_vs_differential_bit;
  } sapc_mux_t;

  typedef struct packed {
    sapc_rx_state_t rx_state;
    logic [3:0] rx_cnt;
    logic [7:0] rx_sr;
    logic [3:0] conv_cnt;
    logic [11:0] out_sr;
    logic dout;
    sapc_mux_t mux;
    logic [1:0] pd;
    logic done_tgl;
    logic active;
    logic hold;
  } sapc_link_st_t;

  typedef struct packed {
    sapc_pwr_state_t pwr;
    logic [1:0] applied_pd;
    logic done_seen;
    logic power_on;
    logic reserved_code;
    logic dout_oe;
  } sapc_sys_st_t;

endpackage : sapc_pkg

/* verilog/sapc_sync2.sv */
// Two-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module sapc_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
  } sapc_sync_st_t;

  sapc_sync_st_t sync_reg;
  sapc_sync_st_t sync_next;

  // First stage feeds only the second
  always_comb
  begin
    sync_next.meta = d_i;
    sync_next.q = sync_reg.meta;
  end

  // Both stages move on every edge
  always_ff @(posedge clk_i)
  begin
    sync_reg <= sync_next;
  end

  assign q_o = sync_reg.q;

endmodule : sapc_sync2
`default_nettype wire

/* verif/sapc_properties.sv */
// Port checker for the converter control block
`timescale 1ns/1ns
`default_nettype none
module sapc_properties
  import sapc_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic serial_clock_pin,
  input wire logic res_pin_i,
  input wire logic shutdown_n_pin,
  input wire logic cs_n_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire sapc_mux_t mux_o,
  input wire logic sample_hold_o,
  input wire logic analog_power_on_o,
  input wire sapc_pwr_state_t power_state_o,
  input wire logic reserved_code_o
);
  // ****************************************************************
  // Link timing and power state
  // ****************************************************************
  a_hold_twelve: assert property (@(posedge serial_clock_pin) disable iff (srst_i)
    $rose(sample_hold_o) && !res_pin_i |-> sample_hold_o[*8] ##1 sample_hold_o[*4]
    ##1 !sample_hold_o) else $error("hold not 12");
  a_hold_length: assert property (@(posedge serial_clock_pin) disable iff (srst_i)
    $rose(sample_hold_o) |-> sample_hold_o[*8] ##1 (!sample_hold_o or
    sample_hold_o[*4] ##1 !sample_hold_o)) else $error("hold not 8 or 12");
  a_pad_low: assert property (@(posedge serial_clock_pin) disable iff (srst_i)
    !sample_hold_o && !$past(sample_hold_o) |-> !dout_o) else $error("pad high");
  a_mux_update: assert property (@(posedge serial_clock_pin) disable iff (srst_i)
    !$rose(sample_hold_o) |-> $stable(mux_o)) else $error("mux moved");
  a_shutdown_n_pin_state: assert property (@(posedge clk_i) disable iff (srst_i)
    (!shutdown_n_pin)[*6] |-> power_state_o == SAPC_PWR_SHUTDOWN) else $error("no shutdown");
  a_shutdown_n_pin_power: assert property (@(posedge clk_i) disable iff (srst_i)
    (power_state_o == SAPC_PWR_SHUTDOWN)[*3] |-> !analog_power_on_o) else $error("power on");
  a_wake_full: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(sample_hold_o) && shutdown_n_pin |-> ##[0:6] power_state_o == SAPC_PWR_FULL)
    else $error("no wake");
  a_rsv_down: assert property (@(posedge clk_i) disable iff (srst_i)
    (reserved_code_o && cs_n_i && shutdown_n_pin)[*8] |->
    power_state_o == SAPC_PWR_AUTO_DOWN) else $error("reserved not down");
  a_oe_follow: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(cs_n_i) |-> ##[1:4] dout_oe_o) else $error("output not enabled");
  c_conv: cover property (@(posedge serial_clock_pin) $rose(sample_hold_o));
  c_shutdown_n_pin: cover property (@(posedge clk_i) power_state_o == SAPC_PWR_SHUTDOWN);
  c_rsv: cover property (@(posedge clk_i) reserved_code_o);
endmodule : sapc_properties
bind sapc_top sapc_properties sapc_properties_i (.clk_i, .srst_i, .serial_clock_pin,
  .res_pin_i, .shutdown_n_pin, .cs_n_i, .dout_o, .dout_oe_o, .mux_o, .sample_hold_o,
  .analog_power_on_o, .power_state_o, .reserved_code_o);
`default_nettype wire

/* verif/sapc_host.sv */
// Host controller model for the serial link
`timescale 1ns/1ns
`default_nettype none
module sapc_host (
  input wire logic dout_i,
  output logic serial_clock_pin,
  output logic cs_n_o,
  output logic din_o
);
  logic ph = 1'b0;
  logic run = 1'b0;
  logic [63:0] got;
  event got_ev;
  // ****************************************************************
  // Gated link clock and frames
  // ****************************************************************
  // Same rate in both modes, link clock still between frames
  initial forever #80 ph = ~ph;
  assign serial_clock_pin = ph & run;
  initial cs_n_o = 1'b1;
  initial din_o = 1'b0;
  // Link clock with chip select high
  task automatic tick(input int n);
    @(negedge ph);
    run = 1'b1;
    repeat (n) @(posedge serial_clock_pin);
    @(negedge ph);
    run = 1'b0;
  endtask : tick
  // Bits sent MSB first, result taken mid-period after each rise
  task automatic frame(input logic [63:0] d, input int n);
    @(negedge ph);
    got = '0;
    cs_n_o = 1'b0;
    run = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      din_o = d[63-i];
      @(posedge serial_clock_pin);
      @(negedge ph);
      got[63-i] = dout_i;
    end
    cs_n_o = 1'b1;
    run = 1'b0;
    din_o = ~din_o;
    -> got_ev;
  endtask : frame
endmodule : sapc_host
`default_nettype wire

/* verif/tb_sapc_top.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb_sapc_top
  import sapc_pkg::*;
();
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic res_pin_i = 1'b0;
  logic shutdown_n_pin = 1'b1;
  logic [11:0] adc_code_i = 12'h000;
  logic serial_clock_pin, cs_n_i, din_i, dout_o, dout_oe_o, hold, pwr_on, rsv;
  sapc_mux_t mux_o;
  sapc_pwr_state_t power_state_o;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 75861;
  logic [31:0] r;
  logic [7:0] c;
  logic [63:0] dv, ev;
  logic [63:0] exp_q[$];
  // ****************************************************************
  // Clock, design, host and checks
  // ****************************************************************
  initial forever #5 clk_i = ~clk_i;
  sapc_top sapc_top_i (.clk_i, .srst_i, .serial_clock_pin, .cs_n_i, .din_i, .res_pin_i,
    .shutdown_n_pin, .adc_code_i, .dout_o, .dout_oe_o, .mux_o, .sample_hold_o(hold),
    .analog_power_on_o(pwr_on), .power_state_o, .reserved_code_o(rsv));
  sapc_host sapc_host_i (.dout_i(dout_o), .serial_clock_pin, .cs_n_o(cs_n_i), .din_o(din_i));
  task automatic tally_and_finish();
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [63:0] g, input logic [63:0] e, input string what);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask : check
  // Command into the din map, result bits into the expected map
  task automatic put(input logic [7:0] cmd, input int s);
    dv[63-s -: 8] = cmd;
    for (int j = 0; j < ((res_pin_i && cmd[3]) ? 8 : 12); j++)
      ev[55-s-j] = adc_code_i[11-j];
  endtask : put
  task automatic conv(input logic [7:0] c1, c2, input int s2, n);
    @(negedge clk_i);
    dv = '0;
    ev = '0;
    put(c1, 2);
    if (s2 > 0)
      put(c2, 2 + s2);
    exp_q.push_back(ev);
    sapc_host_i.frame(dv, n);
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    check(dout_oe_o, 1'b0, "oe idle");
  endtask : conv
  // Result watcher
  initial forever
  begin
    @(sapc_host_i.got_ev);
    check(sapc_host_i.got, exp_q.pop_front(), "dout");
  end
  // Hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      tally_and_finish;
    end
  end
  // Main sequence
  initial
  begin
    sapc_host_i.tick(5);
    @(posedge clk_i) srst_i <= 1'b0;
    sapc_host_i.tick(3);
    for (int p = 0; p < 4; p++)
    begin
      r = $random(seed);
      @(posedge clk_i) adc_code_i <= r[27:16];
      conv({1'b1, r[6:4], 1'b0, r[2], p[1:0]}, 8'h00, 0, 24);
      check(mux_o, {r[6:4], r[2]}, "mux");
      check({power_state_o, pwr_on, rsv}, {(p == 3) ? SAPC_PWR_FULL : SAPC_PWR_AUTO_DOWN,
        p == 3, p == 1 || p == 2}, "power");
    end
    $display("power codes done");
    @(posedge clk_i) shutdown_n_pin <= 1'b0;
    repeat (10) @(negedge clk_i);
    check({power_state_o, pwr_on}, {SAPC_PWR_SHUTDOWN, 1'b0}, "shutdown");
    @(posedge clk_i) shutdown_n_pin <= 1'b1;
    repeat (10) @(negedge clk_i);
    check({power_state_o, pwr_on}, {SAPC_PWR_FULL, 1'b1}, "resume");
    $display("shutdown done");
    // 8-bit every 11th, then 12-bit every 15th by pin and by bit
    for (int m = 0; m < 3; m++)
    begin
      r = $random(seed);
      c = {1'b1, r[6:4], m != 2, r[2], 2'b11};
      @(posedge clk_i) {res_pin_i, adc_code_i} <= {m != 1, r[27:16]};
      conv(c, c, (m == 0) ? 11 : 15, (m == 0) ? 32 : 40);
    end
    $display("overlap done");
    tally_and_finish;
  end
endmodule : tb_sapc_top
`default_nettype wire
